/* File: rtl/bdio_defines.vh */
// shared constants of the board digital i/o block
`ifndef BDIO_DEFINES_VH
`define BDIO_DEFINES_VH

// ============================================================
// bus geometry
`define BDIO_ADR_W          18
`define BDIO_IDX_W          16
`define BDIO_IDX_LSB        2
`define BDIO_DAT_W          32
`define BDIO_REG_W          8
`define BDIO_PAD_W          24

// ============================================================
// register indices, byte address is four times the index
`define BDIO_IDX_A_DATA     16'h8000
`define BDIO_IDX_A_DIR      16'h8001
`define BDIO_IDX_D_DATA     16'h8008
`define BDIO_IDX_D_DIR      16'h8009
`define BDIO_IDX_E_DATA     16'h800A
`define BDIO_IDX_P1_DATA    16'h8080
`define BDIO_IDX_P2_DATA    16'h8081
`define BDIO_IDX_P3_DATA    16'h8082
`define BDIO_IDX_P_CTRL     16'h8083
`define BDIO_IDX_CFG        16'h8090
`define BDIO_IDX_TSEL       16'h8091

// ============================================================
// reset values and unmapped answer
`define BDIO_RST_BYTE       8'h00
`define BDIO_RST_CFG        3'h0
`define BDIO_RD_NONE        8'h00

// ============================================================
// field positions
`define BDIO_CFG_SPI_BIT    0
`define BDIO_CFG_AD8_BIT    1
`define BDIO_CFG_SER2_BIT   2
`define BDIO_CFG_W          3
`define BDIO_CTL_P1_BIT     0
`define BDIO_CTL_P2_BIT     1
`define BDIO_CTL_P3L_BIT    2
`define BDIO_CTL_P3U_BIT    3
`define BDIO_SER2_TX_BIT    3
`define BDIO_SER2_RX_BIT    4
`define BDIO_HC_LSB         5
`define BDIO_HC_N           3
`define BDIO_D_RXD_BIT      0
`define BDIO_D_TXD_BIT      1
`define BDIO_D_GP_LSB       2
`define BDIO_D_GP_W         4
`define BDIO_NIB_W          4

`endif

/* File: rtl/bdio_io_cell.v */
// bidirectional port slice: data latch, direction latch, pin drive
`timescale 1ns/1ps
`include "bdio_defines.vh"

module bdio_io_cell #(
  parameter W = 8
) (
  // clock and reset
  input  wire         clk_i,
  input  wire         rst_i,
  // register writes
  input  wire         dat_we_i,
  input  wire [W-1:0] dir_we_i,
  input  wire [W-1:0] wdat_i,
  input  wire [W-1:0] wdir_i,
  // alternate function takeover
  input  wire [W-1:0] alt_en_i,
  input  wire [W-1:0] alt_dout_i,
  input  wire [W-1:0] alt_den_i,
  // pins
  input  wire [W-1:0] pin_i,
  output wire [W-1:0] pin_o,
  output wire [W-1:0] pin_oe_n_o,
  // register view
  output wire [W-1:0] rd_o,
  output wire [W-1:0] dir_o
);

  reg [W-1:0] out_q;  // output data latch
  reg [W-1:0] dir_q;  // 1 = output

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      // ============================================================
      // per-bit latches, every bit is an input after reset
      always @(posedge clk_i) begin
        if (rst_i) begin
          out_q[i] <= 1'b0;
          dir_q[i] <= 1'b0;                                // RL19
        end else begin
          if (dat_we_i)
            out_q[i] <= wdat_i[i];                         // RL17
          if (dir_we_i[i])
            dir_q[i] <= wdir_i[i];                         // RL18
        end
      end
      // alternate function owns the pin while enabled
      assign pin_o[i]      = alt_en_i[i] ? alt_dout_i[i] : out_q[i];
      assign pin_oe_n_o[i] = alt_en_i[i] ? ~alt_den_i[i] : ~dir_q[i];
      // inputs read the pin level, outputs read back the latch
      assign rd_o[i]       = dir_q[i] ? out_q[i] : pin_i[i];  // RL1
    end
  endgenerate

  assign dir_o = dir_q;

endmodule

/* File: rtl/bdio_wb_if.v */
// classic wishbone handshake: one wait state, registered ack
`timescale 1ns/1ps
`include "bdio_defines.vh"

module bdio_wb_if (
  // clock and reset
  input  wire clk_i,
  input  wire rst_i,
  // bus request
  input  wire cyc_i,
  input  wire stb_i,
  input  wire we_i,
  input  wire sel0_i,
  // answer and strobes
  output wire ack_o,
  output wire wr_o,
  output wire rd_o
);

  reg ack;  // high one cycle per request

  // ============================================================
  // ack rises one edge after the request and drops the next
  always @(posedge clk_i) begin
    if (rst_i)
      ack <= 1'b0;
    else
      ack <= cyc_i & stb_i & ~ack;
  end

  assign ack_o = ack;
  // read data is captured on the same edge ack rises
  assign rd_o  = cyc_i & stb_i & ~ack;
  // writes land on the edge where the master sees ack
  assign wr_o  = cyc_i & stb_i & we_i & sel0_i & ack;

endmodule

/* File: rtl/bdio_top.v */
// board digital i/o ports behind a classic wishbone slave
//
// Function
// RL1 - input pin level reads back as bit value
// RL2 - two 8-bit cpu ports plus four spare bits
// RL3 - three 8-bit adapter ports, own addresses
// RL4 - cpu per bit, adapter bytes, third per nibble
// RL5 - bitwise port per-bit direction, timer takeover
// RL6 - bits 3 and 4 carry secondary serial
// RL7 - serial port: bits 0-1 uart, 2-5 sync serial
// RL8 - sync serial off after reset until enabled
// RL9 - spare bits 2-5 plain i/o when sync off
// RL10 - input port feeds converter or digital reads
// RL11 - converter off after reset
// RL12 - first adapter port has no alternate use
// RL13 - three second-port bits drive high-current outputs
// RL14 - fourth high-current output from programmable logic
// RL15 - third port upper nibble general i/o
// RL16 - software makes upper nibble output for rs485
// RL17 - written 1 drives high, 0 drives low
// RL18 - direction bit 1 output, 0 input
// RL19 - all configurable bits input after reset
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ps
`include "bdio_defines.vh"

module bdio_top (
  // clock and reset
  input  wire                     clk_i,
  input  wire                     rst_i,
  // wishbone slave
  input  wire                     cyc_i,
  input  wire                     stb_i,
  input  wire                     we_i,
  input  wire [3:0]               sel_i,
  input  wire [`BDIO_ADR_W-1:0]   adr_i,
  input  wire [`BDIO_DAT_W-1:0]   dat_i,
  output reg  [`BDIO_DAT_W-1:0]   dat_o,
  output wire                     ack_o,
  // bitwise cpu port pins
  input  wire [7:0]               pa_pin_i,
  output wire [7:0]               pa_pin_o,
  output wire [7:0]               pa_pin_oe_n_o,
  // timer functions on the bitwise port
  input  wire [7:0]               timer_dout_i,
  input  wire [7:0]               timer_den_i,
  output wire [7:0]               timer_din_o,
  // secondary serial channel
  input  wire                     ser2_txd_i,
  output wire                     ser2_rxd_o,
  // serial-shared port pins, bits 0 to 5
  input  wire [5:0]               pd_pin_i,
  output wire [5:0]               pd_pin_o,
  output wire [5:0]               pd_pin_oe_n_o,
  // primary serial channel
  input  wire                     uart_txd_i,
  output wire                     uart_rxd_o,
  // synchronous serial engine, bits 2 to 5
  input  wire [3:0]               spi_dout_i,
  input  wire [3:0]               spi_den_i,
  output wire [3:0]               spi_din_o,
  output wire                     spi_en_o,
  // analog-shared input port
  input  wire [7:0]               pe_pin_i,
  output wire [7:0]               ad8_in_o,
  output wire                     ad8_on_o,
  // adapter port pins
  input  wire [7:0]               p1_pin_i,
  output wire [7:0]               p1_pin_o,
  output wire [7:0]               p1_pin_oe_n_o,
  input  wire [7:0]               p2_pin_i,
  output wire [7:0]               p2_pin_o,
  output wire [7:0]               p2_pin_oe_n_o,
  input  wire [7:0]               p3_pin_i,
  output wire [7:0]               p3_pin_o,
  output wire [7:0]               p3_pin_oe_n_o,
  // high-current driver gates
  input  wire                     pld_hc_i,
  output wire [3:0]               hc_on_o
);

  // ============================================================
  // bus handshake
  wire                    wr_stb;  // write lands this edge
  wire                    rd_stb;  // read data captured this edge
  wire [`BDIO_IDX_W-1:0]  idx;     // word index of the access
  wire [7:0]              wbyte;   // low byte lane of write data

  assign idx   = adr_i[`BDIO_ADR_W-1:`BDIO_IDX_LSB];
  assign wbyte = dat_i[7:0];

  bdio_wb_if u_wb (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .cyc_i  (cyc_i),
    .stb_i  (stb_i),
    .we_i   (we_i),
    .sel0_i (sel_i[0]),
    .ack_o  (ack_o),
    .wr_o   (wr_stb),
    .rd_o   (rd_stb)
  );

  // ============================================================
  // write strobes per register
  wire wr_a_dat;   // bitwise port data
  wire wr_a_dir;   // bitwise port direction
  wire wr_d_dat;   // serial-spare data
  wire wr_d_dir;   // serial-spare direction
  wire wr_p1;      // adapter first port data
  wire wr_p2;      // adapter second port data
  wire wr_p3;      // adapter third port data
  wire wr_ctl;     // adapter direction control
  wire wr_cfg;     // alternate function enables
  wire wr_tsel;    // timer takeover per bit

  assign wr_a_dat = wr_stb & (idx == `BDIO_IDX_A_DATA);
  assign wr_a_dir = wr_stb & (idx == `BDIO_IDX_A_DIR);
  assign wr_d_dat = wr_stb & (idx == `BDIO_IDX_D_DATA);
  assign wr_d_dir = wr_stb & (idx == `BDIO_IDX_D_DIR);
  assign wr_p1    = wr_stb & (idx == `BDIO_IDX_P1_DATA);
  assign wr_p2    = wr_stb & (idx == `BDIO_IDX_P2_DATA);
  assign wr_p3    = wr_stb & (idx == `BDIO_IDX_P3_DATA);
  assign wr_ctl   = wr_stb & (idx == `BDIO_IDX_P_CTRL);
  assign wr_cfg   = wr_stb & (idx == `BDIO_IDX_CFG);
  assign wr_tsel  = wr_stb & (idx == `BDIO_IDX_TSEL);

  // ============================================================
  // alternate function configuration
  reg  [`BDIO_CFG_W-1:0] cfg;   // spi, converter, secondary serial
  reg  [7:0]             tsel;  // bitwise bits handed to timers
  wire                   spi_en;
  wire                   ad8_on;
  wire                   ser2_en;

  // all three engines start off so the shared pins come up digital
  always @(posedge clk_i) begin
    if (rst_i) begin
      cfg  <= `BDIO_RST_CFG;                               // RL8 RL11
      tsel <= `BDIO_RST_BYTE;
    end else begin
      if (wr_cfg)
        cfg <= wbyte[`BDIO_CFG_W-1:0];
      if (wr_tsel)
        tsel <= wbyte;
    end
  end

  assign spi_en   = cfg[`BDIO_CFG_SPI_BIT];                // RL8
  assign ad8_on   = cfg[`BDIO_CFG_AD8_BIT];                // RL11
  assign ser2_en  = cfg[`BDIO_CFG_SER2_BIT];
  assign spi_en_o = spi_en;
  assign ad8_on_o = ad8_on;

  // ============================================================
  // bitwise cpu port, per-bit direction with takeovers
  wire [7:0] s2_mask;   // bits owned by secondary serial
  wire [7:0] s2_dout;   // tx on its bit, zero elsewhere
  wire [7:0] s2_den;    // only the tx bit is driven
  wire [7:0] pa_alt;    // takeover per bit
  wire [7:0] pa_adout;  // takeover data
  wire [7:0] pa_aden;   // takeover drive request
  wire [7:0] pa_rd;     // register view
  wire [7:0] pa_dir;    // direction latch

  // secondary serial wins over the timer on its two pins
  assign s2_mask  = {8{ser2_en}} &
                    ((8'h01 << `BDIO_SER2_TX_BIT) |
                     (8'h01 << `BDIO_SER2_RX_BIT));        // RL6
  assign s2_dout  = {8{ser2_txd_i}} & (8'h01 << `BDIO_SER2_TX_BIT);
  assign s2_den   = 8'h01 << `BDIO_SER2_TX_BIT;
  assign pa_alt   = tsel | s2_mask;                        // RL5
  assign pa_adout = (timer_dout_i & ~s2_mask) | (s2_dout & s2_mask);
  assign pa_aden  = (timer_den_i & ~s2_mask) | (s2_den & s2_mask);

  bdio_io_cell #(.W(8)) u_pa (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .dat_we_i   (wr_a_dat),
    .dir_we_i   ({8{wr_a_dir}}),                           // RL4 RL5
    .wdat_i     (wbyte),
    .wdir_i     (wbyte),
    .alt_en_i   (pa_alt),
    .alt_dout_i (pa_adout),
    .alt_den_i  (pa_aden),
    .pin_i      (pa_pin_i),
    .pin_o      (pa_pin_o),
    .pin_oe_n_o (pa_pin_oe_n_o),
    .rd_o       (pa_rd),
    .dir_o      (pa_dir)
  );

  assign timer_din_o = pa_pin_i;
  assign ser2_rxd_o  = pa_pin_i[`BDIO_SER2_RX_BIT];

  // ============================================================
  // serial-shared port: two uart bits, four spare bits
  wire [3:0] pd_rd;    // spare bits register view
  wire [3:0] pd_dir;   // spare bits direction
  wire [3:0] pd_gp_o;  // spare bits pin data
  wire [3:0] pd_gp_oe; // spare bits enables, low drives

  // the sync serial engine owns bits 2-5 only while enabled
  bdio_io_cell #(.W(`BDIO_D_GP_W)) u_pd (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .dat_we_i   (wr_d_dat),
    .dir_we_i   ({`BDIO_D_GP_W{wr_d_dir}}),                // RL9
    .wdat_i     (wbyte[`BDIO_D_GP_LSB+:`BDIO_D_GP_W]),
    .wdir_i     (wbyte[`BDIO_D_GP_LSB+:`BDIO_D_GP_W]),
    .alt_en_i   ({`BDIO_D_GP_W{spi_en}}),                  // RL7
    .alt_dout_i (spi_dout_i),
    .alt_den_i  (spi_den_i),
    .pin_i      (pd_pin_i[`BDIO_D_GP_LSB+:`BDIO_D_GP_W]),
    .pin_o      (pd_gp_o),
    .pin_oe_n_o (pd_gp_oe),
    .rd_o       (pd_rd),
    .dir_o      (pd_dir)
  );

  // bits 0 and 1 stay with the uart and ignore the direction latch
  assign pd_pin_o      = {pd_gp_o, uart_txd_i, 1'b0};      // RL7
  assign pd_pin_oe_n_o = {pd_gp_oe, 1'b0, 1'b1};
  assign uart_rxd_o    = pd_pin_i[`BDIO_D_RXD_BIT];
  assign spi_din_o     = pd_pin_i[`BDIO_D_GP_LSB+:`BDIO_D_GP_W];

  // ============================================================
  // analog-shared input port, never driven
  // while the converter is on the pins are analog, so reads give 0
  assign ad8_in_o = pe_pin_i;                              // RL10

  // ============================================================
  // adapter ports
  wire [7:0] p1_rd;    // first port view
  wire [7:0] p1_dir;   // first port direction
  wire [7:0] p2_rd;    // second port view
  wire [7:0] p2_dir;   // second port direction
  wire [7:0] p2_out;   // second port pin data
  wire [7:0] p3_rd;    // third port view
  wire [7:0] p3_dir;   // third port direction
  wire [7:0] p3_dwe;   // third port direction write, every bit on wr_ctl

  // first port: plain byte i/o, no alternate use
  bdio_io_cell #(.W(8)) u_p1 (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .dat_we_i   (wr_p1),
    .dir_we_i   ({8{wr_ctl}}),                             // RL4
    .wdat_i     (wbyte),
    .wdir_i     ({8{wbyte[`BDIO_CTL_P1_BIT]}}),
    .alt_en_i   (`BDIO_RST_BYTE),                          // RL12
    .alt_dout_i (`BDIO_RST_BYTE),
    .alt_den_i  (`BDIO_RST_BYTE),
    .pin_i      (p1_pin_i),
    .pin_o      (p1_pin_o),
    .pin_oe_n_o (p1_pin_oe_n_o),
    .rd_o       (p1_rd),
    .dir_o      (p1_dir)
  );

  // second port: byte direction, top bits gate the drivers
  bdio_io_cell #(.W(8)) u_p2 (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .dat_we_i   (wr_p2),
    .dir_we_i   ({8{wr_ctl}}),                             // RL4
    .wdat_i     (wbyte),
    .wdir_i     ({8{wbyte[`BDIO_CTL_P2_BIT]}}),
    .alt_en_i   (`BDIO_RST_BYTE),
    .alt_dout_i (`BDIO_RST_BYTE),
    .alt_den_i  (`BDIO_RST_BYTE),
    .pin_i      (p2_pin_i),
    .pin_o      (p2_out),
    .pin_oe_n_o (p2_pin_oe_n_o),
    .rd_o       (p2_rd),
    .dir_o      (p2_dir)
  );

  assign p2_pin_o = p2_out;

  // drivers 0-2 turn on only for a bit set as output and written 1,
  // so a floating input after reset never energises a load
  assign hc_on_o[`BDIO_HC_N-1:0] =
    p2_out[`BDIO_HC_LSB+:`BDIO_HC_N] &
    p2_dir[`BDIO_HC_LSB+:`BDIO_HC_N];                      // RL13
  assign hc_on_o[`BDIO_HC_N] = pld_hc_i;                   // RL14

  // third port: each nibble has its own direction bit
  assign p3_dwe = {8{wr_ctl}};
  bdio_io_cell #(.W(8)) u_p3 (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .dat_we_i   (wr_p3),
    .dir_we_i   (p3_dwe),                                  // RL4
    .wdat_i     (wbyte),
    .wdir_i     ({{`BDIO_NIB_W{wbyte[`BDIO_CTL_P3U_BIT]}},
                  {`BDIO_NIB_W{wbyte[`BDIO_CTL_P3L_BIT]}}}), // RL15
    .alt_en_i   (`BDIO_RST_BYTE),
    .alt_dout_i (`BDIO_RST_BYTE),
    .alt_den_i  (`BDIO_RST_BYTE),
    .pin_i      (p3_pin_i),
    .pin_o      (p3_pin_o),
    .pin_oe_n_o (p3_pin_oe_n_o),
    .rd_o       (p3_rd),
    .dir_o      (p3_dir)
  );
  // transceiver direction is just bit 4 driven as an output;
  // software must set the upper nibble to output first (RL16)

  // ============================================================
  // read multiplexer
  reg [7:0] rdata;  // byte selected by the index

  // unmapped indices still answer, with zero data
  always @* begin
    if (idx == `BDIO_IDX_A_DATA) begin
      rdata = pa_rd;                                       // RL1 RL2
    end else if (idx == `BDIO_IDX_A_DIR) begin
      rdata = pa_dir;
    end else if (idx == `BDIO_IDX_D_DATA) begin
      // uart bits show their pins, top two bits do not exist
      rdata = {2'b00, pd_rd, pd_pin_i[`BDIO_D_TXD_BIT],
               pd_pin_i[`BDIO_D_RXD_BIT]};                 // RL2
    end else if (idx == `BDIO_IDX_D_DIR) begin
      rdata = {2'b00, pd_dir, 2'b00};
    end else if (idx == `BDIO_IDX_E_DATA) begin
      rdata = ad8_on ? `BDIO_RD_NONE : pe_pin_i;           // RL10
    end else if (idx == `BDIO_IDX_P1_DATA) begin
      rdata = p1_rd;                                       // RL3
    end else if (idx == `BDIO_IDX_P2_DATA) begin
      rdata = p2_rd;                                       // RL3
    end else if (idx == `BDIO_IDX_P3_DATA) begin
      rdata = p3_rd;                                       // RL3
    end else if (idx == `BDIO_IDX_P_CTRL) begin
      rdata = {4'h0, p3_dir[`BDIO_NIB_W], p3_dir[0],
               p2_dir[0], p1_dir[0]};
    end else if (idx == `BDIO_IDX_CFG) begin
      rdata = {5'h00, cfg};
    end else if (idx == `BDIO_IDX_TSEL) begin
      rdata = tsel;
    end else begin
      rdata = `BDIO_RD_NONE;
    end
  end

  // ============================================================
  // read data register, loaded on the edge that raises ack
  always @(posedge clk_i) begin
    if (rst_i)
      dat_o <= {`BDIO_DAT_W{1'b0}};
    else if (rd_stb)
      dat_o <= {{`BDIO_PAD_W{1'b0}}, rdata};
  end

endmodule

/* File: bench/bdio_monitor.sv */
// assertion checker watching the board digital i/o top ports
`timescale 1ns/1ps
module bdio_monitor (
  // clock, reset and bus
  input logic        clk_i,
  input logic        rst_i,
  input logic        cyc_i,
  input logic        stb_i,
  input logic        we_i,
  input logic        ack_o,
  input logic [31:0] dat_o,
  // cpu side pins and functions
  input logic [7:0]  pa_pin_i,
  input logic [7:0]  pa_pin_oe_n_o,
  input logic        ser2_rxd_o,
  input logic [5:0]  pd_pin_i,
  input logic [5:0]  pd_pin_o,
  input logic [5:0]  pd_pin_oe_n_o,
  input logic        uart_txd_i,
  input logic        uart_rxd_o,
  input logic        spi_en_o,
  input logic        ad8_on_o,
  // adapter pins and drivers
  input logic [7:0]  p1_pin_oe_n_o,
  input logic [7:0]  p2_pin_o,
  input logic [7:0]  p2_pin_oe_n_o,
  input logic [7:0]  p3_pin_oe_n_o,
  input logic        pld_hc_i,
  input logic [3:0]  hc_on_o
);
  // ============================================================
  // single clock domain, reset silences every check
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  ack_time_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered in one cycle");
  rd_pad_a: assert property (ack_o |-> dat_o[31:8] == 24'h0)
    else $error("upper read bits not zero");
  // pins other than the uart pair come up undriven after any reset
  rst_input_a: assert property ($past(rst_i) |-> &{pa_pin_oe_n_o,
    p1_pin_oe_n_o, p2_pin_oe_n_o, p3_pin_oe_n_o, pd_pin_oe_n_o[5:2]})
    else $error("pin driven right after reset");
  cfg_wr_a: assert property ($rose(spi_en_o) || $rose(ad8_on_o)
    |-> $past(ack_o && we_i)) else $error("engine on without a write");
  uart_pins_a: assert property (pd_pin_oe_n_o[1:0] == 2'h1
    && pd_pin_o[1] == uart_txd_i && uart_rxd_o == pd_pin_i[0])
    else $error("primary serial bits misrouted");
  ser2_rx_a: assert property (ser2_rxd_o == pa_pin_i[4])
    else $error("secondary receive not from bit 4");
  hc_gate_a: assert property (hc_on_o == {pld_hc_i,
    p2_pin_o[7:5] & ~p2_pin_oe_n_o[7:5]}) else $error("driver gate wrong");
  nib_dir_a: assert property (p3_pin_oe_n_o[3:0] inside {4'h0, 4'hF}
    && p3_pin_oe_n_o[7:4] inside {4'h0, 4'hF}
    && p1_pin_oe_n_o inside {8'h00, 8'hFF}) else $error("split direction");
  // the first port direction only moves on a write or a reset
  pin_hold_a: assert property ($changed(p1_pin_oe_n_o)
    |-> $past(ack_o && we_i) || $past(rst_i)) else $error("stray drive");

  cover property (ack_o && !we_i);
  cover property (spi_en_o);
  cover property (ad8_on_o);
  cover property (hc_on_o[2:0] != 3'h0);
endmodule

/* File: bench/bdio_pins_model.sv */
// far-side switches and loads answering on one port's pins
`timescale 1ns/1ps
module bdio_pins_model #(
  parameter W = 8
) (
  // switch level, dut drive and enable, resulting wire level
  input  logic [W-1:0] sw_i,
  input  logic [W-1:0] drv_i,
  input  logic [W-1:0] oe_n_i,
  output logic [W-1:0] lvl_o
);
  // switches sit behind resistors, so a driving dut wins the wire
  assign lvl_o = (drv_i & ~oe_n_i) | (sw_i & oe_n_i);
endmodule

/* File: bench/bdio_top_tb.sv */
// self-checking bench for the board digital i/o block
`timescale 1ns/1ps
`include "bdio_defines.vh"
module bdio_top_tb;
  // ============================================================
  // signals, named as the dut ports
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, ser2_txd_i, ser2_rxd_o;
  logic uart_txd_i, uart_rxd_o, spi_en_o, ad8_on_o, pld_hc_i;
  logic [3:0]  sel_i, spi_dout_i, spi_den_i, spi_din_o, hc_on_o;
  logic [17:0] adr_i;
  logic [31:0] dat_i, dat_o;
  logic [7:0]  pa_pin_i, pa_pin_o, pa_pin_oe_n_o, pe_pin_i, ad8_in_o;
  logic [7:0]  timer_dout_i, timer_den_i, timer_din_o;
  logic [7:0]  p1_pin_i, p1_pin_o, p1_pin_oe_n_o, p2_pin_i, p2_pin_o;
  logic [7:0]  p2_pin_oe_n_o, p3_pin_i, p3_pin_o, p3_pin_oe_n_o;
  logic [5:0]  pd_pin_i, pd_pin_o, pd_pin_oe_n_o, sw_pd;
  logic [7:0]  sw_pa, sw_p1, sw_p2, sw_p3, r, m;
  logic [23:0] q;
  logic [23:0] expq[$];     // pending reads: index and expected byte
  int          mismatches, n_tests, cyc_n;

  bdio_top dut_u (.*);
  bdio_pins_model #(.W(8)) pa_m (.sw_i(sw_pa), .drv_i(pa_pin_o),
    .oe_n_i(pa_pin_oe_n_o), .lvl_o(pa_pin_i));
  bdio_pins_model #(.W(6)) pd_m (.sw_i(sw_pd), .drv_i(pd_pin_o),
    .oe_n_i(pd_pin_oe_n_o), .lvl_o(pd_pin_i));
  bdio_pins_model #(.W(8)) p1_m (.sw_i(sw_p1), .drv_i(p1_pin_o),
    .oe_n_i(p1_pin_oe_n_o), .lvl_o(p1_pin_i));
  bdio_pins_model #(.W(8)) p2_m (.sw_i(sw_p2), .drv_i(p2_pin_o),
    .oe_n_i(p2_pin_oe_n_o), .lvl_o(p2_pin_i));
  bdio_pins_model #(.W(8)) p3_m (.sw_i(sw_p3), .drv_i(p3_pin_o),
    .oe_n_i(p3_pin_oe_n_o), .lvl_o(p3_pin_i));

  // ============================================================
  // helpers
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  // one classic cycle; waits for ack under a bounded count
  task automatic wb(input logic w, input logic [15:0] ix,
                    input logic [7:0] d);
    int t;
    t = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= {ix, 2'b00};
    dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      t++;
    end while (ack_o !== 1'b1 && t < 20);
    if (t >= 20) begin
      mismatches++;
      $display("mismatch ack exp 1 got %b", ack_o);
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [15:0] ix, input logic [7:0] d);
    wb(1'b1, ix, d);
  endtask
  task automatic rd(input logic [15:0] ix, input logic [7:0] e);
    expq.push_back({ix, e});
    wb(1'b0, ix, 8'h00);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ============================================================
  // clock, timeout and read-data watcher
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      mismatches++;
      $display("mismatch cycles exp below %0d got %0d", 20000, cyc_n);
      finish_test();
    end else if (ack_o === 1'b1 && cyc_i && !we_i && expq.size() > 0) begin
      q = expq.pop_front();
      chk($sformatf("reg %h", q[23:8]), q[7:0], dat_o[7:0]);
    end
  end

  // ============================================================
  // main sequence
  initial begin
    r = lfsr(8'h60);
    {rst_i, cyc_i, stb_i, we_i, ser2_txd_i, pld_hc_i} = 6'h20;
    {adr_i, dat_i, sel_i, spi_den_i} = {50'h0, 4'hF, 4'hF};
    {uart_txd_i, spi_dout_i, timer_dout_i, timer_den_i} = {5'h1A, 16'h8080};
    {sw_pa, sw_p1, sw_p2, sw_p3} = {r, ~r, r ^ 8'h5A, lfsr(r)};
    sw_pd = r[5:0];
    pe_pin_i = lfsr(~r);
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(`BDIO_IDX_A_DIR, 8'h00);
    rd(`BDIO_IDX_D_DIR, 8'h00);
    rd(`BDIO_IDX_P_CTRL, 8'h00);
    rd(`BDIO_IDX_CFG, 8'h00);
    rd(`BDIO_IDX_A_DATA, sw_pa);
    rd(`BDIO_IDX_E_DATA, pe_pin_i);
    $display("test reset done");
    repeat (4) begin
      r = lfsr(r);
      m = lfsr(r);
      wr(`BDIO_IDX_A_DATA, r);
      wr(`BDIO_IDX_A_DIR, m);
      chk("pa oe", ~m, pa_pin_oe_n_o);
      chk("pa out", r & m, pa_pin_o & m);
      rd(`BDIO_IDX_A_DATA, (r & m) | (sw_pa & ~m));
    end
    $display("test bitwise port done");
    wr(`BDIO_IDX_D_DIR, 8'hFF);
    wr(`BDIO_IDX_D_DATA, 8'h3C);
    chk("pd oe", 8'h01, {2'b00, pd_pin_oe_n_o});
    chk("pd out", 8'h3C, {2'b00, pd_pin_o} & 8'h3C);
    rd(`BDIO_IDX_D_DATA, {4'hF, uart_txd_i, sw_pd[0]});
    wr(`BDIO_IDX_CFG, 8'h01);
    chk("spi", {3'h1, spi_dout_i}, {spi_en_o, pd_pin_o[5:2]});
    chk("spi in", {4'h0, spi_dout_i}, {4'h0, spi_din_o});
    wr(`BDIO_IDX_CFG, 8'h02);
    chk("ad8 on", 8'h01, {7'h00, ad8_on_o});
    chk("ad8 in", pe_pin_i, ad8_in_o);
    rd(`BDIO_IDX_E_DATA, 8'h00);
    wr(`BDIO_IDX_CFG, 8'h00);
    wr(`BDIO_IDX_E_DATA, 8'hFF);
    rd(`BDIO_IDX_E_DATA, pe_pin_i);
    wr(16'h8050, 8'hA5);
    rd(16'h8050, 8'h00);
    $display("test serial and converter done");
    for (int i = 0; i < 16; i++) begin
      r = lfsr(r);
      pld_hc_i <= r[0];
      wr(`BDIO_IDX_P1_DATA, r);
      wr(`BDIO_IDX_P2_DATA, ~r);
      wr(`BDIO_IDX_P3_DATA, r ^ 8'h3C);
      wr(`BDIO_IDX_P_CTRL, i[7:0]);
      m = {{4{i[3]}}, {4{i[2]}}};
      chk("p1 oe", {8{~i[0]}}, p1_pin_oe_n_o);
      chk("p1 out", r, p1_pin_o);
      chk("p2 oe", {8{~i[1]}}, p2_pin_oe_n_o);
      chk("p3 oe", ~m, p3_pin_oe_n_o);
      chk("p3 out", (r ^ 8'h3C) & m, p3_pin_o & m);
      chk("hc", {r[0], ~r[7:5] & {3{i[1]}}}, {4'h0, hc_on_o});
      rd(`BDIO_IDX_P_CTRL, i[7:0]);
      rd(`BDIO_IDX_P1_DATA, i[0] ? r : sw_p1);
      rd(`BDIO_IDX_P2_DATA, i[1] ? ~r : sw_p2);
      rd(`BDIO_IDX_P3_DATA, ((r ^ 8'h3C) & m) | (sw_p3 & ~m));
    end
    $display("test adapter ports done");
    wr(`BDIO_IDX_A_DIR, 8'h00);
    wr(`BDIO_IDX_CFG, 8'h04);
    for (int i = 0; i < 2; i++) begin
      ser2_txd_i <= i[0];
      @(posedge clk_i);
      chk("ser2", {i[0], 1'b0}, {pa_pin_o[3], pa_pin_oe_n_o[3]});
    end
    wr(`BDIO_IDX_CFG, 8'h00);
    wr(`BDIO_IDX_TSEL, 8'h80);
    chk("timer", 8'h02, {pa_pin_o[7], pa_pin_oe_n_o[7]});
    chk("timer in", 8'h80, timer_din_o & 8'h80);
    $display("test alternate uses done");
    wr(`BDIO_IDX_A_DIR, 8'hFF);
    wr(`BDIO_IDX_CFG, 8'h03);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("rst oe", 8'hFF, pa_pin_oe_n_o & p1_pin_oe_n_o);
    chk("rst cfg", 8'h00, {spi_en_o, ad8_on_o});
    rd(`BDIO_IDX_A_DIR, 8'h00);
    $display("test second reset done");
    finish_test();
  end
endmodule

bind bdio_top bdio_monitor mon_u (.*);
